// *** common/sccc_pkg.sv ***
// Register map, field layout and codes of the capture/compare channel
package sccc_pkg;
    // Register byte offsets
    localparam logic [7:0] SCCC_OFS_INTEN = 8'h0c;
    localparam logic [7:0] SCCC_OFS_FLAG = 8'h10;
    localparam logic [7:0] SCCC_OFS_SWEV = 8'h14;
    localparam logic [7:0] SCCC_OFS_MODE = 8'h18;
    localparam logic [7:0] SCCC_OFS_POL = 8'h20;
    localparam logic [7:0] SCCC_OFS_VAL = 8'h34;
    localparam logic [7:0] SCCC_OFS_CFG = 8'h40;
    localparam logic [7:0] SCCC_OFS_STAT = 8'h44;
    // Reset values
    localparam logic [15:0] SCCC_RST_16 = 16'h0000;
    localparam logic [7:0] SCCC_RST_MODE = 8'h00;
    localparam logic [5:0] SCCC_RST_CFG = 6'h00;
    // Enable and flag bit positions
    localparam int SCCC_BIT_UPD = 0;
    localparam int SCCC_BIT_CHAN = 1;
    localparam int SCCC_BIT_OVC = 9;
    // Mode register fields
    localparam int SCCC_BIT_FAST = 2;
    localparam int SCCC_BIT_SHADOW = 3;
    localparam int SCCC_CTL_LSB = 4;
    localparam int SCCC_PSC_LSB = 2;
    localparam int SCCC_FLT_LSB = 4;
    // Polarity/enable register fields
    localparam int SCCC_BIT_EN = 0;
    localparam int SCCC_BIT_P = 1;
    localparam int SCCC_BIT_NP = 3;
    // Own configuration register fields
    localparam int SCCC_CFG_SAMP_LSB = 0;
    localparam int SCCC_CFG_LOCK_LSB = 2;
    localparam int SCCC_CFG_ITSV = 4;
    localparam int SCCC_CFG_EVT = 5;
    // Compare output control codes
    localparam logic [2:0] SCCC_CMP_FROZEN = 3'h0;
    localparam logic [2:0] SCCC_CMP_SET = 3'h1;
    localparam logic [2:0] SCCC_CMP_CLR = 3'h2;
    localparam logic [2:0] SCCC_CMP_TOG = 3'h3;
    localparam logic [2:0] SCCC_CMP_FLOW = 3'h4;
    localparam logic [2:0] SCCC_CMP_FHIGH = 3'h5;
    localparam logic [2:0] SCCC_CMP_PWM0 = 3'h6;
    localparam logic [2:0] SCCC_CMP_PWM1 = 3'h7;
    // Channel io mode codes
    localparam logic [1:0] SCCC_IO_OUT = 2'h0;
    localparam logic [1:0] SCCC_IO_PIN = 2'h1;
    localparam logic [1:0] SCCC_IO_TRG = 2'h3;
    // Write protection level that locks compare control, shadow enable and complementary polarity
    localparam logic [1:0] SCCC_LOCK_FULL = 2'h3;
endpackage

// *** design/sccc_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - Event mode lets hardware start counter
// - Enables: channel bit 1, update bit 0
// - Capture while flag set raises over-capture
// - Channel flag on capture or compare match
// - Update flag set on each update event
// - Soft channel event sets flag, self-clears
// - Soft input event captures counter value
// - Soft update clears counter, self-clears
// - Frozen, set, clear, toggle on match
// - Forced low and forced high modes
// - PWM0 active below value counting up
// - PWM1 inverse of PWM0 levels
// - PWM level changes on comparison change or fast trigger
// - Compare control and shadow fields locked at full protection in output mode
// - Shadowed value loads on update event
// - Fast trigger edge forces compare level in PWM modes
// - Io mode writable only while disabled
// - Filter code picks sample rate, count
// - Capture every 1, 2, 4, 8 edges
// - Edge divider cleared while channel disabled
// - Complementary polarity for output and input
// - Complementary polarity locked by protection
// - Polarity pair selects active edges
// - Value register read-only capture in input
module sccc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] counter_value,
    input wire logic count_down,
    input wire logic update_event,
    input wire logic trigger_in,
    input wire logic chan_pin_in,
    output logic chan_output_pin,
    output logic chan_output_pin_n,
    output logic chan_irq,
    output logic update_irq,
    output logic counter_clear,
    output logic counter_run_set
);
    import sccc_pkg::*;

    // Filter length N per code
    function automatic logic [3:0] sccc_filt_n(input logic [3:0] c);
        logic [3:0] n;
        n = 4'h6;
        if (c == 4'h0) n = 4'h1;
        else if (c == 4'h1) n = 4'h2;
        else if (c == 4'h2) n = 4'h4;
        else if (c == 4'h3 || c == 4'h5 || c == 4'h7 || c == 4'h9) n = 4'h8;
        else if (c == 4'hc || c == 4'hf) n = 4'h8;
        else if (c == 4'ha || c == 4'hd) n = 4'h5;
        return n;
    endfunction

    // Sampling divider of the filter, in sampling-clock periods
    function automatic logic [5:0] sccc_filt_m(input logic [3:0] c);
        logic [5:0] m;
        m = 6'h20;
        if (c == 4'h0) m = 6'h01;
        else if (c <= 4'h3) m = 6'h00;
        else if (c <= 4'h5) m = 6'h02;
        else if (c <= 4'h7) m = 6'h04;
        else if (c <= 4'h9) m = 6'h08;
        else if (c <= 4'hc) m = 6'h10;
        return m;
    endfunction

    // Bus handshake terms
    logic pready_reg;
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready_reg;
    wire wr = acc & pwrite;
    wire hit_inten = paddr == SCCC_OFS_INTEN;
    wire hit_flag = paddr == SCCC_OFS_FLAG;
    wire hit_swev = paddr == SCCC_OFS_SWEV;
    wire hit_mode = paddr == SCCC_OFS_MODE;
    wire hit_pol = paddr == SCCC_OFS_POL;
    wire hit_val = paddr == SCCC_OFS_VAL;
    wire hit_cfg = paddr == SCCC_OFS_CFG;
    wire hit_stat = paddr == SCCC_OFS_STAT;
    wire hit_any = hit_inten | hit_flag | hit_swev | hit_mode | hit_pol
        | hit_val | hit_cfg | hit_stat;

    // Software-visible state
    logic [1:0] inten_reg; // Irq enables
    logic chan_flag_reg; // Channel event flag
    logic upd_flag_reg; // Update flag
    logic ovc_flag_reg; // Over-capture flag
    logic chan_sw_reg; // Soft channel event, one cycle
    logic upd_sw_reg; // Soft update, one cycle
    logic [7:0] mode_reg; // Mode/compare/filter fields
    logic [3:0] pol_reg; // Polarity and enable
    logic [15:0] val_reg; // Active compare or capture value
    logic [15:0] shadow_reg; // Buffered compare value
    logic [5:0] cfg_reg; // Sampling div, protection, trigger opts

    // Field decode
    wire [2:0] cmp_ctl = mode_reg[SCCC_CTL_LSB +: 3];
    wire shadow_en = mode_reg[SCCC_BIT_SHADOW];
    wire fast_en = mode_reg[SCCC_BIT_FAST];
    wire [1:0] io_mode = mode_reg[1:0];
    wire [3:0] filt_code = mode_reg[SCCC_FLT_LSB +: 4];
    wire [1:0] edge_div = mode_reg[SCCC_PSC_LSB +: 2];
    wire chan_en = pol_reg[SCCC_BIT_EN];
    wire pol_main = pol_reg[SCCC_BIT_P];
    wire pol_comp = pol_reg[SCCC_BIT_NP];
    wire [1:0] samp_div = cfg_reg[SCCC_CFG_SAMP_LSB +: 2];
    wire [1:0] lock_level = cfg_reg[SCCC_CFG_LOCK_LSB +: 2];
    wire trig_sel_valid = cfg_reg[SCCC_CFG_ITSV];
    wire event_mode = cfg_reg[SCCC_CFG_EVT];
    wire out_mode = io_mode == SCCC_IO_OUT;
    wire in_mode = io_mode[0];

    // Write strobes per register
    wire wr_inten = wr & hit_inten;
    wire wr_flag = wr & hit_flag;
    wire wr_swev = wr & hit_swev;
    wire wr_mode = wr & hit_mode;
    wire wr_pol = wr & hit_pol;
    wire wr_val = wr & hit_val;
    wire wr_cfg = wr & hit_cfg;

    // Protection: compare control and shadow fields freeze at full lock in output mode; fast enable stays writable
    wire c0_lock = (lock_level == SCCC_LOCK_FULL) && out_mode;
    wire [7:0] mode_next = {pwdata[7],
        c0_lock ? mode_reg[6:3] : pwdata[6:3],
        pwdata[2],
        chan_en ? mode_reg[1:0] : pwdata[1:0]};
    // Complementary polarity locked at either upper protection level
    wire [3:0] pol_next = {lock_level[1] ? pol_reg[3] : pwdata[3],
        1'b0, pwdata[1:0]};

    // Input synchroniser, first stage read only by the second
    logic pin_s1_reg;
    logic pin_s2_reg;
    // Filter sampling and state
    logic [7:0] samp_cnt_reg;
    logic [3:0] filt_cnt_reg;
    logic filt_out_reg;
    // Sample period in timer clocks; fast codes ignore the divider
    wire [5:0] filt_m = sccc_filt_m(filt_code);
    wire [7:0] samp_per = (filt_m == 6'h00) ? 8'h01
        : 8'({2'b00, filt_m} << (samp_div == 2'h0 ? 0 : samp_div == 2'h1 ? 1 : 2));
    wire samp_tick = samp_cnt_reg >= samp_per - 8'h01;
    wire [3:0] filt_n = sccc_filt_n(filt_code);
    wire filt_diff = pin_s2_reg != filt_out_reg;
    wire filt_flip = samp_tick & filt_diff & (filt_cnt_reg + 4'h1 >= filt_n);

    // Input source and edge selection
    wire in_src = (io_mode == SCCC_IO_TRG) ? (trigger_in & trig_sel_valid) : filt_out_reg;
    wire in_inv = pol_main & ~pol_comp;
    wire in_both = pol_main & pol_comp;
    wire in_lvl = in_src ^ in_inv;
    logic in_lvl_reg;
    wire in_edge = in_both ? (in_lvl ^ in_lvl_reg) : (in_lvl & ~in_lvl_reg);

    // Capture edge divider
    logic [2:0] edge_cnt_reg;
    wire [2:0] edge_lim = (edge_div == 2'h0) ? 3'h0 : (edge_div == 2'h1) ? 3'h1
        : (edge_div == 2'h2) ? 3'h3 : 3'h7;
    wire cap_edge = chan_en & in_mode & in_edge;
    wire cap_hw = cap_edge & (edge_cnt_reg == edge_lim);
    wire cap_evt = cap_hw | (chan_sw_reg & in_mode);

    // Compare match, once per arrival at the value
    logic match_reg;
    wire match = counter_value == val_reg;
    wire cmp_hit = out_mode & match & ~match_reg;
    wire chan_evt = chan_sw_reg | cap_hw | cmp_hit;
    wire upd_evt = update_event | upd_sw_reg;

    // Flag next values; a new event beats a clear in the same cycle
    wire chan_flag_next = chan_evt
        | (chan_flag_reg & ~(wr_flag & ~pwdata[SCCC_BIT_CHAN]));
    wire upd_flag_next = upd_evt
        | (upd_flag_reg & ~(wr_flag & ~pwdata[SCCC_BIT_UPD]));
    wire ovc_set = cap_evt & chan_flag_reg;
    wire ovc_flag_next = ovc_set
        | (ovc_flag_reg & ~(wr_flag & ~pwdata[SCCC_BIT_OVC]));

    // Output prepare and fast trigger path
    logic prep_reg;
    logic prep_next;
    logic trig_reg;
    logic fast_reg;
    wire trig_rise = trigger_in & ~trig_reg;
    wire is_pwm = cmp_ctl[2] & cmp_ctl[1];
    wire pwm_cmp = count_down ? ~(counter_value > val_reg)
        : (counter_value < val_reg);
    wire pwm_lvl = pwm_cmp ^ (cmp_ctl == SCCC_CMP_PWM1);
    wire fast_hit = fast_en & is_pwm & trig_rise;

    // Read mux; reserved bits read zero
    wire [31:0] rdata = hit_inten ? {30'h0, inten_reg}
        : hit_flag ? {22'h0, ovc_flag_reg, 7'h0, chan_flag_reg, upd_flag_reg}
        : hit_swev ? {30'h0, chan_sw_reg, upd_sw_reg}
        : hit_mode ? {24'h0, mode_reg}
        : hit_pol ? {28'h0, pol_reg}
        : hit_val ? {16'h0, val_reg}
        : hit_cfg ? {26'h0, cfg_reg}
        : hit_stat ? {29'h0, in_lvl_reg, filt_out_reg, prep_reg}
        : 32'h0;

    // Prepare level per compare mode
    always_comb begin
        prep_next = prep_reg;
        unique case (cmp_ctl)
            SCCC_CMP_FROZEN: prep_next = prep_reg;
            SCCC_CMP_SET: prep_next = cmp_hit | prep_reg;
            SCCC_CMP_CLR: prep_next = ~cmp_hit & prep_reg;
            SCCC_CMP_TOG: prep_next = cmp_hit ^ prep_reg;
            SCCC_CMP_FLOW: prep_next = 1'b0;
            SCCC_CMP_FHIGH: prep_next = 1'b1;
            // Follows the comparison, held high for one cycle by the fast trigger path
            SCCC_CMP_PWM0, SCCC_CMP_PWM1: prep_next = fast_reg | pwm_lvl;
        endcase
    end

    // Bus answer: one wait-free access phase, data latched at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready_reg <= setup;
            if (setup) begin
                prdata <= rdata;
                pslverr <= ~hit_any;
            end
        end
    end
    assign pready = pready_reg;

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inten_reg <= 2'h0;
            mode_reg <= SCCC_RST_MODE;
            pol_reg <= 4'h0;
            cfg_reg <= SCCC_RST_CFG;
        end else if (ce) begin
            if (wr_inten) inten_reg <= pwdata[1:0];
            if (wr_mode) mode_reg <= mode_next;
            if (wr_pol) pol_reg <= pol_next;
            if (wr_cfg) cfg_reg <= pwdata[5:0];
        end
    end

    // Flags and self-clearing soft events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_flag_reg <= 1'b0;
            upd_flag_reg <= 1'b0;
            ovc_flag_reg <= 1'b0;
            chan_sw_reg <= 1'b0;
            upd_sw_reg <= 1'b0;
        end else if (ce) begin
            chan_flag_reg <= chan_flag_next;
            upd_flag_reg <= upd_flag_next;
            ovc_flag_reg <= ovc_flag_next;
            // Hardware drops the bit one cycle after it acts
            chan_sw_reg <= wr_swev & pwdata[SCCC_BIT_CHAN];
            upd_sw_reg <= wr_swev & pwdata[SCCC_BIT_UPD];
        end
    end

    // Channel value with shadow and capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_reg <= SCCC_RST_16;
            shadow_reg <= SCCC_RST_16;
        end else if (ce) begin
            if (cap_evt) begin
                val_reg <= counter_value;
            end else if (wr_val && out_mode && !shadow_en) begin
                val_reg <= pwdata[15:0];
            end else if (upd_evt && out_mode && shadow_en) begin
                val_reg <= shadow_reg;
            end
            // Software cannot write it in input mode
            if (wr_val && out_mode && shadow_en) shadow_reg <= pwdata[15:0];
        end
    end

    // Synchroniser and digital filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            samp_cnt_reg <= 8'h0;
            filt_cnt_reg <= 4'h0;
            filt_out_reg <= 1'b0;
        end else if (ce) begin
            pin_s1_reg <= chan_pin_in;
            pin_s2_reg <= pin_s1_reg;
            samp_cnt_reg <= samp_tick ? 8'h0 : samp_cnt_reg + 8'h01;
            // Any agreeing sample restarts the run
            if (samp_tick) begin
                if (!filt_diff || filt_flip) filt_cnt_reg <= 4'h0;
                else filt_cnt_reg <= filt_cnt_reg + 4'h1;
                if (filt_flip) filt_out_reg <= pin_s2_reg;
            end
        end
    end

    // Edge history and capture divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_lvl_reg <= 1'b0;
            edge_cnt_reg <= 3'h0;
            // Counter and value both start at zero: no false match after reset
            match_reg <= 1'b1;
            trig_reg <= 1'b0;
        end else if (ce) begin
            in_lvl_reg <= in_lvl;
            match_reg <= match;
            trig_reg <= trigger_in;
            if (!chan_en) edge_cnt_reg <= 3'h0;
            else if (cap_edge) edge_cnt_reg <= cap_hw ? 3'h0 : edge_cnt_reg + 3'h1;
        end
    end

    // Output prepare and pins; pins lag prepare by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_reg <= 1'b0;
            prep_reg <= 1'b0;
            chan_output_pin <= 1'b0;
            chan_output_pin_n <= 1'b0;
        end else if (ce) begin
            fast_reg <= fast_hit;
            prep_reg <= prep_next;
            chan_output_pin <= chan_en & out_mode & (prep_reg ^ pol_main);
            chan_output_pin_n <= chan_en & out_mode & (~prep_reg ^ pol_comp);
        end
    end

    // Irq levels and counter side pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_irq <= 1'b0;
            update_irq <= 1'b0;
            counter_clear <= 1'b0;
            counter_run_set <= 1'b0;
        end else if (ce) begin
            chan_irq <= chan_flag_next & inten_reg[SCCC_BIT_CHAN];
            update_irq <= upd_flag_next & inten_reg[SCCC_BIT_UPD];
            counter_clear <= upd_sw_reg;
            // Hardware start only in event mode; others rely on software
            counter_run_set <= event_mode & trig_rise;
        end
    end

    // Checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_chan_flag;
        ce && chan_evt |=> chan_flag_reg;
    endproperty
    a_chan_flag: assert property (p_chan_flag) else $error("chan flag missed");

    property p_upd_flag;
        ce && upd_evt |=> upd_flag_reg;
    endproperty
    a_upd_flag: assert property (p_upd_flag) else $error("update flag missed");

    property p_clear;
        ce && wr_flag && !pwdata[1] && !chan_evt |=> !chan_flag_reg;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    property p_ovc;
        ce && cap_evt && chan_flag_reg |=> ovc_flag_reg;
    endproperty
    a_ovc: assert property (p_ovc) else $error("over-capture missed");

    property p_sw_self;
        ce && chan_sw_reg && !wr_swev |=> !chan_sw_reg;
    endproperty
    a_sw_self: assert property (p_sw_self) else $error("soft event stuck");

    property p_psc_rst;
        ce && !chan_en |=> edge_cnt_reg == 3'h0;
    endproperty
    a_psc_rst: assert property (p_psc_rst) else $error("edge divider kept");

    property p_flow;
        ce && cmp_ctl == SCCC_CMP_FLOW ##1 ce |=> !chan_output_pin || $past(pol_main);
    endproperty
    a_flow: assert property (p_flow) else $error("forced low not low");

    property p_fast;
        (ce && fast_hit) ##1 ce ##1 ce |=> chan_output_pin == (chan_en & out_mode & ~pol_main);
    endproperty
    a_fast: assert property (p_fast) else $error("fast path late");

    property p_lock;
        ce && wr_mode && c0_lock |=> cmp_ctl == $past(cmp_ctl);
    endproperty
    a_lock: assert property (p_lock) else $error("locked field written");

    property p_io_lock;
        ce && wr_mode && chan_en |=> io_mode == $past(io_mode);
    endproperty
    a_io_lock: assert property (p_io_lock) else $error("io mode written");

    property p_capture;
        ce && cap_evt |=> val_reg == $past(counter_value);
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost");

    c_capture: cover property (ce && cap_hw && edge_lim == 3'h7);
    c_ovc: cover property (ce && ovc_set);
    c_fast: cover property (ce && fast_hit);
    c_shadow: cover property (ce && upd_evt && shadow_en && out_mode);

endmodule // sccc_top

// *** sim/sccc_partner.sv ***
`timescale 1ns/1ps
// Far side of the channel: counter source, channel pin and trigger
module sccc_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic pin_lvl,
    input wire logic trig_lvl,
    input wire logic counter_clear,
    output logic [15:0] counter_value,
    output logic count_down,
    output logic update_event,
    output logic chan_pin_in,
    output logic trigger_in
);
    // Counter moves only while software has it running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value <= 16'h0000;
        end else if (counter_clear) begin
            counter_value <= 16'h0000;
        end else if (run) begin
            counter_value <= counter_value + 16'h0001;
        end
    end
    // Up only, no wrap event: update flag stays under software control
    assign count_down = 1'b0;
    assign update_event = 1'b0;
    assign chan_pin_in = pin_lvl;
    assign trigger_in = trig_lvl;
endmodule // sccc_partner

// *** sim/tb.sv ***
`timescale 1ns/1ps
// Register-level bench for the capture/compare channel
module tb;
    import sccc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rq;
    logic pready, pslverr, last_err, chan_output_pin, chan_output_pin_n;
    logic chan_irq, update_irq, counter_clear, counter_run_set;
    logic count_down, update_event, trigger_in, chan_pin_in;
    logic [15:0] counter_value;
    logic run = 1'b0;
    logic pin_lvl = 1'b0;
    logic trig_lvl = 1'b0;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [7:0] offs [5] = '{SCCC_OFS_INTEN, SCCC_OFS_FLAG, SCCC_OFS_SWEV,
        SCCC_OFS_MODE, SCCC_OFS_POL};
    always #50 pclk = ~pclk;
    sccc_top uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .counter_value(counter_value),
        .count_down(count_down), .update_event(update_event), .trigger_in(trigger_in),
        .chan_pin_in(chan_pin_in), .chan_output_pin(chan_output_pin),
        .chan_output_pin_n(chan_output_pin_n), .chan_irq(chan_irq),
        .update_irq(update_irq), .counter_clear(counter_clear),
        .counter_run_set(counter_run_set));
    sccc_partner far_side (.pclk(pclk), .presetn(presetn), .run(run), .pin_lvl(pin_lvl),
        .trig_lvl(trig_lvl), .counter_clear(counter_clear), .counter_value(counter_value),
        .count_down(count_down), .update_event(update_event), .chan_pin_in(chan_pin_in),
        .trigger_in(trigger_in));
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; idle edge first so no signal is set twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        repeat (16) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rq = prdata;
        last_err = pslverr;
        check({31'h0, pready}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rq, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One rising pin edge; spacing covers the synchroniser and filter
    task automatic rise;
        pin_lvl <= 1'b0;
        tick(8);
        pin_lvl <= 1'b1;
        tick(8);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #1000000;
        n_mismatch++;
        close_out;
    end
    initial begin
        tick(2);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(offs[i], 32'h0);
        end
        wr(SCCC_OFS_INTEN, 32'h3);
        rd(SCCC_OFS_INTEN, 32'h3);
        rd(8'h08, 32'h0);
        check({31'h0, last_err}, 32'h1);
        // Software capture in input mode with a frozen counter of 7
        wr(SCCC_OFS_MODE, 32'h01);
        wr(SCCC_OFS_POL, 32'h01);
        run <= 1'b1;
        tick(7);
        run <= 1'b0;
        wr(SCCC_OFS_SWEV, 32'h2);
        tick(3);
        rd(SCCC_OFS_FLAG, 32'h2);
        check({31'h0, chan_irq}, 32'h1);
        rd(SCCC_OFS_VAL, 32'h7);
        wr(SCCC_OFS_SWEV, 32'h2);
        tick(3);
        rd(SCCC_OFS_FLAG, 32'h202);
        wr(SCCC_OFS_VAL, 32'h1234);
        rd(SCCC_OFS_VAL, 32'h7);
        wr(SCCC_OFS_FLAG, 32'h200);
        rd(SCCC_OFS_FLAG, 32'h200);
        check({31'h0, chan_irq}, 32'h0);
        wr(SCCC_OFS_MODE, 32'h00);
        rd(SCCC_OFS_MODE, 32'h01);
        // Capture on every second rising edge; disable restarts the count
        wr(SCCC_OFS_FLAG, 32'h0);
        wr(SCCC_OFS_POL, 32'h0);
        wr(SCCC_OFS_MODE, 32'h05);
        wr(SCCC_OFS_POL, 32'h1);
        rise;
        rd(SCCC_OFS_FLAG, 32'h0);
        rise;
        rd(SCCC_OFS_FLAG, 32'h2);
        wr(SCCC_OFS_FLAG, 32'h0);
        rise;
        wr(SCCC_OFS_POL, 32'h0);
        wr(SCCC_OFS_POL, 32'h1);
        rise;
        rd(SCCC_OFS_FLAG, 32'h0);
        // Forced output levels and both polarities
        wr(SCCC_OFS_POL, 32'h0);
        wr(SCCC_OFS_MODE, 32'h40);
        wr(SCCC_OFS_POL, 32'h1);
        tick(4);
        check({31'h0, chan_output_pin}, 32'h0);
        check({31'h0, chan_output_pin_n}, 32'h1);
        wr(SCCC_OFS_MODE, 32'h50);
        tick(4);
        check({31'h0, chan_output_pin}, 32'h1);
        wr(SCCC_OFS_POL, 32'h03);
        tick(4);
        check({31'h0, chan_output_pin}, 32'h0);
        wr(SCCC_OFS_POL, 32'h0b);
        tick(4);
        check({31'h0, chan_output_pin_n}, 32'h1);
        // Full protection locks compare control and complementary polarity
        wr(SCCC_OFS_CFG, 32'h0c);
        wr(SCCC_OFS_MODE, 32'h40);
        rd(SCCC_OFS_MODE, 32'h50);
        wr(SCCC_OFS_POL, 32'h03);
        rd(SCCC_OFS_POL, 32'h0b);
        // Software update clears the counter and raises the update flag
        wr(SCCC_OFS_FLAG, 32'h0);
        wr(SCCC_OFS_SWEV, 32'h1);
        tick(3);
        rd(SCCC_OFS_FLAG, 32'h1);
        check({31'h0, update_irq}, 32'h1);
        check({16'h0, counter_value}, 32'h0);
        // Unlocked, event mode: shadowed value, toggle on match
        wr(SCCC_OFS_CFG, 32'h20);
        wr(SCCC_OFS_MODE, 32'h38);
        wr(SCCC_OFS_POL, 32'h01);
        wr(SCCC_OFS_VAL, 32'h5);
        rd(SCCC_OFS_VAL, 32'h7);
        wr(SCCC_OFS_SWEV, 32'h1);
        rd(SCCC_OFS_VAL, 32'h5);
        wr(SCCC_OFS_FLAG, 32'h0);
        check({31'h0, chan_output_pin}, 32'h1);
        run <= 1'b1;
        tick(8);
        run <= 1'b0;
        tick(2);
        check({31'h0, chan_output_pin}, 32'h0);
        rd(SCCC_OFS_FLAG, 32'h2);
        // PWM with fast trigger path; counter stands at 8, value 5
        wr(SCCC_OFS_MODE, 32'h64);
        trig_lvl <= 1'b1;
        tick(2);
        check({31'h0, counter_run_set}, 32'h1);
        tick(2);
        check({31'h0, chan_output_pin}, 32'h1);
        tick(1);
        check({31'h0, chan_output_pin}, 32'h0);
        trig_lvl <= 1'b0;
        wr(SCCC_OFS_VAL, 32'h10);
        tick(3);
        check({31'h0, chan_output_pin}, 32'h1);
        wr(SCCC_OFS_MODE, 32'h74);
        tick(3);
        check({31'h0, chan_output_pin}, 32'h0);
        close_out;
    end
endmodule // tb
